// ### logic/pedr_pkg.sv
// Constants and carrier types for the port link error flag register
package pedr_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int ACKID_W = 6;
  localparam int TMO_W = 24;
  localparam logic [23:0] FLAGS_ADDR = 24'h002040;
  localparam logic [23:0] TMO_ADDR = 24'h002080;
  localparam int BIT_IMPL = 0;
  localparam int BIT_CS_CRC = 9;
  localparam int BIT_ACK_SEQ = 10;
  localparam int BIT_PNA = 11;
  localparam int BIT_PKT_SEQ = 12;
  localparam int BIT_PKT_CRC = 13;
  localparam int BIT_PKT_LONG = 14;
  localparam int BIT_BAD_CHAR = 15;
  localparam int BIT_IDLE_DATA = 16;
  localparam int BIT_DESCR = 17;
  localparam int BIT_NOT_OUT = 26;
  localparam int BIT_PROTO = 27;
  localparam int BIT_DELIN = 29;
  localparam int BIT_UNSOL = 30;
  localparam int BIT_TMO = 31;
  // Implemented flag bits; all others are reserved zeros
  localparam logic [31:0] FLAGS_MASK = 32'hEC03FE01;
  localparam logic [31:0] FLAGS_RESET = 32'h00000000;
  localparam int MAX_PKT_BYTES = 276;
  localparam int CLK_MHZ = 100;
  localparam int TMO_US = 10;
  localparam int TMO_CYC = TMO_US * CLK_MHZ;
  localparam logic [23:0] TMO_RESET = TMO_CYC[23:0];

  // One-cycle event pulses from the receive and link-protocol logic
  typedef struct packed {
    logic impl_err;
    logic cs_bad_crc;
    logic ack_pna;
    logic pkt_bad_crc;
    logic invalid_char;
    logic illegal_char;
    logic data_in_idle1;
    logic descr_sync_loss;
    logic lr_not_outstanding;
    logic proto_err;
    logic misplaced_cg;
    logic unsolicited_ack;
  } pedr_rx_event_type;

  // An ackID seen on the link together with the value expected
  typedef struct packed {
    logic valid;
    logic [ACKID_W-1:0] id;
    logic [ACKID_W-1:0] expected;
  } pedr_ackid_type;
endpackage

// ### logic/pedr_pkt_len_check.sv
// Received packet length checker
`timescale 1ns/1ps
`default_nettype none
module pedr_pkt_len_check #(
  parameter int MAX_BYTES = pedr_pkg::MAX_PKT_BYTES
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_byte_valid,
  input wire logic i_sop,
  input wire logic i_eop,
  output logic o_too_long
);
  localparam int CNT_W = $clog2(MAX_BYTES + 2);
  localparam logic [CNT_W-1:0] CNT_MAX = MAX_BYTES[CNT_W-1:0];
  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic seen_reg;
  logic seen_next;
  logic too_long_next;
  wire logic [CNT_W-1:0] base;
  wire logic over;

  // A start byte restarts the count even if the old end was lost
  assign base = i_sop ? '0 : cnt_reg;
  assign over = i_byte_valid && (base == CNT_MAX) && !(seen_reg && !i_sop);

  always_comb
  begin
    cnt_next = cnt_reg;
    seen_next = seen_reg;
    too_long_next = 1'b0;
    if (i_byte_valid)
    begin
      if (base != CNT_MAX)
      begin
        cnt_next = base + CNT_ONE;
      end
      else
      begin
        cnt_next = base;
      end
      seen_next = i_sop ? 1'b0 : seen_reg;
      if (over)
      begin
        too_long_next = 1'b1;
        seen_next = 1'b1;
      end
      if (i_eop)
      begin
        cnt_next = '0;
        seen_next = 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_reg <= '0;
      seen_reg <= 1'b0;
      o_too_long <= 1'b0;
    end
    else if (i_ce)
    begin
      cnt_reg <= cnt_next;
      seen_reg <= seen_next;
      o_too_long <= too_long_next;
    end
  end
endmodule // pedr_pkt_len_check
`default_nettype wire

// ### logic/pedr_port_error_detect.sv
// Port link error flag register with Avalon-MM slave
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module pedr_port_error_detect #(
  parameter int ADDR_W = pedr_pkg::ADDR_W,
  parameter int ACKID_W = pedr_pkg::ACKID_W,
  parameter int MAX_PKT_BYTES = pedr_pkg::MAX_PKT_BYTES,
  parameter logic [23:0] TMO_DEFAULT = pedr_pkg::TMO_RESET
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire pedr_pkg::pedr_rx_event_type i_rx_event,
  input wire pedr_pkg::pedr_ackid_type i_ack_chk,
  input wire pedr_pkg::pedr_ackid_type i_pkt_chk,
  input wire logic i_rx_byte_valid,
  input wire logic i_rx_sop,
  input wire logic i_rx_eop,
  input wire logic i_ack_wait,
  output logic [31:0] o_port_link_error_flags,
  output logic o_link_timeout
);
  logic [31:0] flags_reg;
  logic [31:0] flags_next;
  logic [23:0] tmo_reg;
  logic [23:0] tmo_next;
  logic [23:0] wait_cnt_reg;
  logic [23:0] wait_cnt_next;
  logic fired_reg;
  logic fired_next;
  logic tmo_pulse_next;
  logic wait_reg;
  logic wait_next;
  logic [31:0] rdata_next;
  logic [31:0] set_vec;
  wire logic pkt_too_long;
  wire logic req;
  wire logic accept;
  wire logic sel_flags;
  wire logic sel_tmo;
  wire logic wr_flags;
  wire logic wr_tmo;
  wire logic ack_seq_err;
  wire logic pkt_seq_err;
  wire logic bad_char;
  wire logic tmo_hit;
  wire logic [31:0] flags_written;
  wire logic [31:0] tmo_written;
  wire logic [31:0] rd_mux;

  // Byte-lane merge shared by every writable register
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  pedr_pkt_len_check #(
    .MAX_BYTES(MAX_PKT_BYTES)
  ) u_len (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_byte_valid(i_rx_byte_valid),
    .i_sop(i_rx_sop),
    .i_eop(i_rx_eop),
    .o_too_long(pkt_too_long)
  );

  // Bus handshake: one wait cycle, then the request is served
  assign req = i_avs_read || i_avs_write;
  assign accept = req && !wait_reg;
  assign sel_flags = (i_avs_address == pedr_pkg::FLAGS_ADDR[ADDR_W-1:0]);
  assign sel_tmo = (i_avs_address == pedr_pkg::TMO_ADDR[ADDR_W-1:0]);
  assign wr_flags = accept && i_avs_write && sel_flags;
  assign wr_tmo = accept && i_avs_write && sel_tmo;

  // Link checks derived from ackID comparisons, plus the merged bad-character check
  assign ack_seq_err = i_ack_chk.valid && (i_ack_chk.id != i_ack_chk.expected);
  assign pkt_seq_err = i_pkt_chk.valid && (i_pkt_chk.id != i_pkt_chk.expected);
  assign bad_char = i_rx_event.invalid_char || i_rx_event.illegal_char;

  // Zero in tmo_reg disables the watchdog
  assign tmo_hit = i_ack_wait && !fired_reg && (tmo_reg != 24'h000000)
    && (wait_cnt_reg >= tmo_reg - 24'h000001);

  always_comb
  begin
    set_vec = 32'h00000000;
    set_vec[pedr_pkg::BIT_IMPL] = i_rx_event.impl_err;
    set_vec[pedr_pkg::BIT_CS_CRC] = i_rx_event.cs_bad_crc;
    set_vec[pedr_pkg::BIT_ACK_SEQ] = ack_seq_err;
    set_vec[pedr_pkg::BIT_PNA] = i_rx_event.ack_pna;
    set_vec[pedr_pkg::BIT_PKT_SEQ] = pkt_seq_err;
    set_vec[pedr_pkg::BIT_PKT_CRC] = i_rx_event.pkt_bad_crc;
    set_vec[pedr_pkg::BIT_PKT_LONG] = pkt_too_long;
    set_vec[pedr_pkg::BIT_BAD_CHAR] = bad_char;
    set_vec[pedr_pkg::BIT_IDLE_DATA] = i_rx_event.data_in_idle1;
    set_vec[pedr_pkg::BIT_DESCR] = i_rx_event.descr_sync_loss;
    set_vec[pedr_pkg::BIT_NOT_OUT] = i_rx_event.lr_not_outstanding;
    set_vec[pedr_pkg::BIT_PROTO] = i_rx_event.proto_err;
    // Delineation also marks bad and idle-data characters
    set_vec[pedr_pkg::BIT_DELIN] = bad_char || i_rx_event.misplaced_cg
      || i_rx_event.data_in_idle1;
    set_vec[pedr_pkg::BIT_UNSOL] = i_rx_event.unsolicited_ack;
    set_vec[pedr_pkg::BIT_TMO] = tmo_hit;
  end

  // Writing one leaves a flag alone; a set in the same cycle as a clear wins
  assign flags_written = flags_reg & be_merge(32'hFFFFFFFF, i_avs_writedata,
    i_avs_byteenable);
  assign tmo_written = be_merge({8'h00, tmo_reg}, i_avs_writedata, i_avs_byteenable);

  always_comb
  begin
    flags_next = wr_flags ? flags_written : flags_reg;
    flags_next = (flags_next | set_vec) & pedr_pkg::FLAGS_MASK;
  end

  assign tmo_next = wr_tmo ? tmo_written[23:0] : tmo_reg;

  // Wait counter runs only while an answer is owed
  always_comb
  begin
    wait_cnt_next = wait_cnt_reg;
    fired_next = fired_reg;
    tmo_pulse_next = tmo_hit;
    if (!i_ack_wait)
    begin
      wait_cnt_next = 24'h000000;
      fired_next = 1'b0;
    end
    else
    begin
      if (wait_cnt_reg != 24'hFFFFFF)
      begin
        wait_cnt_next = wait_cnt_reg + 24'h000001;
      end
      if (tmo_hit)
      begin
        fired_next = 1'b1;
      end
    end
  end

  // Unmapped addresses read zero; reserved bits read zero
  assign rd_mux = sel_flags ? (flags_reg & pedr_pkg::FLAGS_MASK) :
    (sel_tmo ? {8'h00, tmo_reg} : 32'h00000000);

  always_comb
  begin
    wait_next = 1'b1;
    rdata_next = o_avs_readdata;
    if (req && wait_reg)
    begin
      wait_next = 1'b0;
      rdata_next = i_avs_read ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      flags_reg <= pedr_pkg::FLAGS_RESET;
      o_port_link_error_flags <= pedr_pkg::FLAGS_RESET;
      tmo_reg <= TMO_DEFAULT;
    end
    else if (i_ce)
    begin
      flags_reg <= flags_next;
      o_port_link_error_flags <= flags_next;
      tmo_reg <= tmo_next;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wait_cnt_reg <= 24'h000000;
      fired_reg <= 1'b0;
      o_link_timeout <= 1'b0;
    end
    else if (i_ce)
    begin
      wait_cnt_reg <= wait_cnt_next;
      fired_reg <= fired_next;
      o_link_timeout <= tmo_pulse_next;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wait_reg <= 1'b1;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
    end
    else if (i_ce)
    begin
      wait_reg <= wait_next;
      o_avs_waitrequest <= wait_next;
      o_avs_readdata <= rdata_next;
    end
  end
endmodule // pedr_port_error_detect
`default_nettype wire

// ### dv/pedr_port_error_detect_monitor.sv
// Assertion checker for the port link error flag register
`timescale 1ns/1ps
`default_nettype none
module pedr_port_error_detect_monitor #(
  parameter int ADDR_W = 24
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire pedr_pkg::pedr_rx_event_type i_rx_event,
  input wire pedr_pkg::pedr_ackid_type i_ack_chk,
  input wire pedr_pkg::pedr_ackid_type i_pkt_chk,
  input wire logic [31:0] o_port_link_error_flags,
  input wire logic o_link_timeout
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic [31:0] f = o_port_link_error_flags;
  chk_rsvd_zero: assert property ((f & ~pedr_pkg::FLAGS_MASK) == 32'h00000000)
    else $error("reserved flag bit set");
  chk_impl_set: assert property (i_rx_event.impl_err |=> f[0])
    else $error("flag 0 not set");
  chk_crc_set: assert property (i_rx_event.cs_bad_crc |=> f[9])
    else $error("flag 9 not set");
  chk_ack_seq: assert property (i_ack_chk.valid && i_ack_chk.id != i_ack_chk.expected |=> f[10])
    else $error("flag 10 not set");
  chk_pna_set: assert property (i_rx_event.ack_pna |=> f[11])
    else $error("flag 11 not set");
  chk_pkt_seq: assert property (i_pkt_chk.valid && i_pkt_chk.id != i_pkt_chk.expected |=> f[12])
    else $error("flag 12 not set");
  chk_char_set: assert property (i_rx_event.invalid_char || i_rx_event.illegal_char |=> f[15] && f[29])
    else $error("flags 15 and 29 not set");
  chk_idle_set: assert property (i_rx_event.data_in_idle1 |=> f[16])
    else $error("flag 16 not set");
  // Only a served write to the flag word may clear a bit
  chk_flag_sticky: assert property (|($past(f) & ~f) |-> $past(i_avs_write && !o_avs_waitrequest && i_avs_address == pedr_pkg::FLAGS_ADDR))
    else $error("flag cleared without write");
  chk_tmo_flag: assert property (o_link_timeout |-> f[31] ##1 !o_link_timeout)
    else $error("time-out pulse or flag wrong");
endmodule // pedr_port_error_detect_monitor
bind pedr_port_error_detect pedr_port_error_detect_monitor #(.ADDR_W(ADDR_W)) i_mon (.*);
`default_nettype wire

// ### dv/pedr_link_partner_model.sv
// Behavioural model of the remote link partner's receive-side events
`timescale 1ns/1ps
`default_nettype none
module pedr_link_partner_model (
  input wire logic i_core_clk,
  output var pedr_pkg::pedr_rx_event_type o_ev,
  output var pedr_pkg::pedr_ackid_type o_ack,
  output var pedr_pkg::pedr_ackid_type o_pkt,
  output var logic o_bv,
  output var logic o_sop,
  output var logic o_eop,
  output var logic o_ack_wait
);
  initial {o_ev, o_ack, o_pkt, o_bv, o_sop, o_eop, o_ack_wait} = '0;
  task automatic pulse(input pedr_pkg::pedr_rx_event_type m);
    @(posedge i_core_clk);
    o_ev <= m;
    @(posedge i_core_clk);
    o_ev <= '0;
  endtask
  task automatic seen(input logic pk, input logic [5:0] id, input logic [5:0] ex);
    @(posedge i_core_clk);
    if (pk) o_pkt <= {1'b1, id, ex};
    else o_ack <= {1'b1, id, ex};
    @(posedge i_core_clk);
    o_pkt <= '0;
    o_ack <= '0;
  endtask
  // Back-to-back bytes, the hardest case for the length count
  task automatic send(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge i_core_clk);
      o_bv <= 1'b1;
      o_sop <= (i == 0);
      o_eop <= (i == n - 1);
    end
    @(posedge i_core_clk);
    {o_bv, o_sop, o_eop} <= 3'h0;
  endtask
  task automatic owe(input logic v);
    @(posedge i_core_clk);
    o_ack_wait <= v;
  endtask
endmodule // pedr_link_partner_model
`default_nettype wire

// ### dv/pedr_port_error_detect_tb_top.sv
// Self-checking testbench for the port link error flag register
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR %0t: got %h exp %h", $time, a, e); end end
module pedr_port_error_detect_tb_top;
  localparam logic [23:0] FA = pedr_pkg::FLAGS_ADDR;
  logic clk, rst_n, rd, wr, wq, bv, sop, eop, aw;
  logic [23:0] addr;
  logic [31:0] wd, q, rdat, flg;
  logic lto;
  int tmo_seen;
  logic [3:0] be;
  pedr_pkg::pedr_rx_event_type ev;
  pedr_pkg::pedr_ackid_type ack, pkt;
  int bad_count, samples_checked;
  logic [31:0] exp_ev [12] = '{32'h00000001, 32'h00000200, 32'h00000800, 32'h00002000,
    32'h20008000, 32'h20008000, 32'h20010000, 32'h00020000, 32'h04000000, 32'h08000000,
    32'h20000000, 32'h40000000};
  pedr_port_error_detect i_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wq),
    .i_rx_event(ev), .i_ack_chk(ack), .i_pkt_chk(pkt), .i_rx_byte_valid(bv),
    .i_rx_sop(sop), .i_rx_eop(eop), .i_ack_wait(aw), .o_port_link_error_flags(flg),
    .o_link_timeout(lto));
  // Counts time-out pulses; each wait must fire once only
  always @(posedge clk)
  begin
    if (lto === 1'b1) tmo_seen++;
  end
  pedr_link_partner_model i_peer (.i_core_clk(clk), .o_ev(ev), .o_ack(ack), .o_pkt(pkt),
    .o_bv(bv), .o_sop(sop), .o_eop(eop), .o_ack_wait(aw));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic bus(input logic we, input logic [23:0] a, input logic [31:0] d);
    @(posedge clk);
    {rd, wr, addr, wd} <= {!we, we, a, d};
    do @(posedge clk); while (wq !== 1'b0);
    q = rdat;
    {rd, wr} <= 2'h0;
  endtask
  task automatic chk_rd(input logic [23:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    `CHK(q, e)
    if (a == FA) `CHK(flg, e)
  endtask
  task automatic summarize;
    if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    {rd, wr, addr, wd, be, bad_count, samples_checked} = '0;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    be <= 4'hF;
    chk_rd(FA, 32'h00000000);
    chk_rd(pedr_pkg::TMO_ADDR, {8'h00, pedr_pkg::TMO_RESET});
    chk_rd(24'h002044, 32'h00000000);
    bus(1'b1, FA, 32'hFFFFFFFF);
    chk_rd(FA, 32'h00000000);
    for (int i = 0; i < 12; i++)
    begin
      i_peer.pulse(pedr_pkg::pedr_rx_event_type'(12'h800 >> i));
      chk_rd(FA, exp_ev[i]);
      bus(1'b1, FA, 32'h00000000);
      chk_rd(FA, 32'h00000000);
    end
    for (int j = 0; j < 3; j++)
    begin
      i_peer.seen(j == 2, 6'h05, (j == 0) ? 6'h05 : 6'h06);
      chk_rd(FA, (j == 0) ? 32'h0 : ((j == 1) ? 32'h00000400 : 32'h00001000));
      bus(1'b1, FA, 32'h00000000);
    end
    i_peer.send(276);
    chk_rd(FA, 32'h00000000);
    i_peer.send(277);
    chk_rd(FA, 32'h00004000);
    bus(1'b1, FA, 32'h00000000);
    bus(1'b1, pedr_pkg::TMO_ADDR, 32'h00000008);
    i_peer.owe(1'b1);
    repeat (12) @(posedge clk);
    chk_rd(FA, 32'h80000000);
    `CHK(tmo_seen, 1)
    i_peer.owe(1'b0);
    // Clear and detection land on the same edge
    fork
      bus(1'b1, FA, 32'h00000000);
      begin
        @(posedge clk);
        i_peer.pulse(pedr_pkg::pedr_rx_event_type'(12'h800));
      end
    join
    chk_rd(FA, 32'h00000001);
    be <= 4'h0;
    bus(1'b1, FA, 32'h00000000);
    chk_rd(FA, 32'h00000001);
    summarize;
  end
  initial
  begin
    repeat (6000) @(posedge clk);
    bad_count++;
    summarize;
  end
endmodule // pedr_port_error_detect_tb_top
`default_nettype wire
